// ==== logic/rsc_pkg.sv ====
package rsc_pkg;
  // Register byte addresses
  localparam logic [4:0] ADDR_FLAGS    = 5'h00;
  localparam logic [4:0] ADDR_SOFT_RESET = 5'h04;
  localparam logic [4:0] ADDR_PROTECT  = 5'h08;
  localparam logic [4:0] ADDR_IRQ_STAT = 5'h0C;
  localparam logic [4:0] ADDR_IRQ_EN   = 5'h10;
  localparam logic [4:0] ADDR_IRQ_CLR  = 5'h14;
  // Cause flag positions
  localparam int FLAG_POR  = 0;
  localparam int FLAG_BOD  = 1;
  localparam int FLAG_PIN  = 2;
  localparam int FLAG_WDT  = 3;
  localparam int FLAG_SOFT = 4;
  localparam int FLAG_DBG  = 5;
  localparam int NFLAGS    = 6;
  localparam logic [5:0] FLAGS_POR_ONLY = 6'h01;
  localparam int SOFT_TRIGGER_BIT = 0;
  // Interrupt status positions
  localparam int IRQ_BOOT_DONE = 0;
  localparam int IRQ_REFUSED   = 1;
  localparam int NIRQ          = 2;
  // Unlock key, value arbitrary
  localparam logic [7:0] IO_UNLOCK_KEY = 8'h5A;
  localparam logic [2:0] UNLOCK_WINDOW = 3'h4;
  // Brown-out level floor when unused
  localparam logic [2:0] BOD_LEVEL_MIN = 3'h0;
  // Scan select value meaning no startup scan
  localparam logic [1:0] SCAN_NONE = 2'h0;
  // Timing
  localparam int CLK_PERIOD_NS     = 50;
  localparam int INIT_BASE_NS      = 300;
  localparam int INIT_BASE_CYCLES  = (INIT_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STARTUP_STEP_US   = 1000;
  localparam int STARTUP_STEP_CYC  = STARTUP_STEP_US * 1000 / CLK_PERIOD_NS;
  localparam int SCAN_CYCLES       = 256;
  localparam int CNT_W             = 24;
  typedef enum logic [1:0] {
    RSC_RUN  = 2'b00,
    RSC_HOLD = 2'b01,
    RSC_INIT = 2'b10
  } rsc_state_e;
endpackage

// ==== logic/rsc_sync2.sv ====
`timescale 1ns/100ps
`default_nettype none
module rsc_sync2 #(
  parameter int Width = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rstN,
  // Data
  input  wire logic [Width-1:0] din,
  output logic      [Width-1:0] dout
);
  typedef struct packed {
    logic [Width-1:0] meta;
    logic [Width-1:0] stable;
  } rsc_sync_s;
  rsc_sync_s sQ, sD;

  always_comb begin
    sD.meta   = din;
    sD.stable = sQ.meta;
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      sQ <= '0;
    end else begin
      sQ <= sD;
    end
  end

  assign dout = sQ.stable;
endmodule // rsc_sync2
`default_nettype wire

// ==== logic/rsc_reset_gen.sv ====
`timescale 1ns/100ps
`default_nettype none
module rsc_reset_gen (
  // Clock and asynchronous assert
  input  wire logic clk,
  input  wire logic arstN,
  // Synchronous release permission
  input  wire logic relOk,
  output logic      rstN
);
  typedef struct packed {
    logic s0;
    logic s1;
  } rsc_rg_s;
  rsc_rg_s gQ, gD;

  always_comb begin
    gD.s0 = relOk;
    gD.s1 = gQ.s0;
  end

  always_ff @(posedge clk or negedge arstN) begin
    if (!arstN) begin
      gQ <= '0;
    end else begin
      gQ <= gD;
    end
  end

  assign rstN = gQ.s1;
endmodule // rsc_reset_gen
`default_nettype wire

// ==== logic/rsc_reset_manager.sv ====
// The implementer's own choice: the Avalon-MM slave port.
`timescale 1ns/100ps
`default_nettype none
module rsc_reset_manager #(
  parameter int StartupStepCycles = rsc_pkg::STARTUP_STEP_CYC,
  parameter int ScanCycles        = rsc_pkg::SCAN_CYCLES
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  // Reset requesters
  input  wire logic        porLowDet,
  input  wire logic        bodLowDet,
  input  wire logic        resetPinN,
  input  wire logic        wdtExpire,
  input  wire logic        debugRstReq,
  // Fuse values
  input  wire logic        resetPinConfig,
  input  wire logic [2:0]  startupDelaySetting,
  input  wire logic [1:0]  startupScanSelect,
  input  wire logic        bodUsed,
  input  wire logic [2:0]  bodLevelFuse,
  // Reset outputs
  output logic             sysRstN,
  output logic             debugRstN,
  output logic             fuseReload,
  output logic             initBusy,
  output logic [2:0]       bodLevel,
  // Avalon-MM slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Interrupt
  output logic             irq
);
  localparam int MaxLen = rsc_pkg::INIT_BASE_CYCLES + 7 * StartupStepCycles + ScanCycles;

  initial begin
    if (StartupStepCycles < 1 || ScanCycles < 0 || MaxLen >= (1 << rsc_pkg::CNT_W)) begin
      $error("rsc_reset_manager: counts do not fit the init counter");
    end
  end

  typedef struct packed {
    rsc_pkg::rsc_state_e        state;
    logic [rsc_pkg::CNT_W-1:0]  cnt;
    logic [rsc_pkg::NFLAGS-1:0] pend;
    logic [rsc_pkg::NFLAGS-1:0] flags;
    logic [2:0]                 unlock;
    logic                       swReq;
    logic [rsc_pkg::NIRQ-1:0]   irqStat;
    logic [rsc_pkg::NIRQ-1:0]   irqEn;
    logic                       irq;
    logic [7:0]                 rdata;
    logic                       wait_;
    logic                       fuseReload;
    logic [2:0]                 bodLevel;
    logic                       initBusy;
  } rsc_st_s;
  rsc_st_s sQ, sD;

  logic [3:0] rawReq;
  logic [3:0] syncReq;
  logic       sPor;
  logic       sBod;
  logic       sPinLow;
  logic       sDbg;
  logic       sysArstN;
  logic       dbgArstN;
  logic       pendPower;

  // pin counts only when its fuse enables it
  assign rawReq = {debugRstReq, resetPinConfig & ~resetPinN, bodLowDet, porLowDet};

  rsc_sync2 #(
    .Width (4)
  ) u_sync (
    .clk  (sys_clk),
    .rstN (resetn),
    .din  (rawReq),
    .dout (syncReq)
  );

  assign sPor    = syncReq[0];
  assign sBod    = syncReq[1];
  assign sPinLow = syncReq[2];
  assign sDbg    = syncReq[3];

  // raw requests (supply, pin, debug) assert at once
  // Synced copy bridges a short pulse until the state machine holds
  assign sysArstN  = resetn & ~(|rawReq) & ~(|syncReq);
  // debug logic reset only by power sources
  assign dbgArstN  = resetn & ~porLowDet & ~bodLowDet & ~sPor & ~sBod;
  assign pendPower = sQ.pend[rsc_pkg::FLAG_POR] | sQ.pend[rsc_pkg::FLAG_BOD];

  rsc_reset_gen u_sys_rst (
    .clk   (sys_clk),
    .arstN (sysArstN),
    .relOk (sQ.state == rsc_pkg::RSC_RUN),
    .rstN  (sysRstN)
  );

  rsc_reset_gen u_dbg_rst (
    .clk   (sys_clk),
    .arstN (dbgArstN),
    .relOk (~pendPower),
    .rstN  (debugRstN)
  );

  logic                       acc;
  logic                       wrOk;
  logic [rsc_pkg::NFLAGS-1:0] nowReq;
  logic [rsc_pkg::NFLAGS-1:0] allPend;
  logic [rsc_pkg::NFLAGS-1:0] flagSet;
  logic [rsc_pkg::NIRQ-1:0]   irqSet;
  logic [rsc_pkg::CNT_W-1:0]  initLen;
  logic                       swAccept;
  logic                       swRefuse;

  always_comb begin
    sD       = sQ;
    acc      = (avs_read | avs_write) & ~sQ.wait_;
    wrOk     = avs_write & acc & avs_byteenable[0];
    flagSet  = '0;
    irqSet   = '0;
    nowReq   = '0;
    nowReq[rsc_pkg::FLAG_POR]  = sPor;
    nowReq[rsc_pkg::FLAG_BOD]  = sBod;
    nowReq[rsc_pkg::FLAG_PIN]  = sPinLow;
    nowReq[rsc_pkg::FLAG_WDT]  = wdtExpire;
    nowReq[rsc_pkg::FLAG_SOFT] = sQ.swReq;
    nowReq[rsc_pkg::FLAG_DBG]  = sDbg;
    allPend  = sQ.pend | nowReq;
    // startup delay only for power resets
    initLen  = rsc_pkg::CNT_W'(rsc_pkg::INIT_BASE_CYCLES);
    if (allPend[rsc_pkg::FLAG_POR] | allPend[rsc_pkg::FLAG_BOD]) begin
      initLen = initLen + rsc_pkg::CNT_W'(startupDelaySetting) *
                rsc_pkg::CNT_W'(StartupStepCycles);
    end
    if (startupScanSelect != rsc_pkg::SCAN_NONE) begin
      initLen = initLen + rsc_pkg::CNT_W'(ScanCycles);
    end

    // Bus handshake: one wait state per access
    sD.wait_ = ~((avs_read | avs_write) & sQ.wait_);
    sD.rdata = '0;
    if (avs_read & sQ.wait_) begin
      unique case (avs_address)
        rsc_pkg::ADDR_FLAGS:    sD.rdata = {2'h0, sQ.flags};
        rsc_pkg::ADDR_SOFT_RESET: sD.rdata = 8'h00;
        rsc_pkg::ADDR_IRQ_STAT: sD.rdata = {6'h00, sQ.irqStat};
        rsc_pkg::ADDR_IRQ_EN:   sD.rdata = {6'h00, sQ.irqEn};
        default:                sD.rdata = 8'h00;
      endcase
    end

    if (sQ.unlock != 3'h0) begin
      sD.unlock = sQ.unlock - 3'h1;
    end
    swAccept = 1'b0;
    swRefuse = 1'b0;
    sD.swReq = 1'b0;
    if (wrOk) begin
      unique case (avs_address)
        rsc_pkg::ADDR_PROTECT: begin
          if (avs_writedata[7:0] == rsc_pkg::IO_UNLOCK_KEY) begin
            sD.unlock = rsc_pkg::UNLOCK_WINDOW;
          end
        end
        rsc_pkg::ADDR_SOFT_RESET: begin
          if (sQ.unlock != 3'h0) begin
            swAccept  = avs_writedata[rsc_pkg::SOFT_TRIGGER_BIT];
            sD.unlock = 3'h0;
          end else begin
            swRefuse = 1'b1;
          end
        end
        rsc_pkg::ADDR_IRQ_EN: sD.irqEn = avs_writedata[rsc_pkg::NIRQ-1:0];
        default: ;
      endcase
    end
    sD.swReq = swAccept;

    sD.fuseReload = 1'b0;
    unique case (sQ.state)
      rsc_pkg::RSC_RUN: begin
        if (|nowReq) begin
          sD.pend  = nowReq;
          sD.state = rsc_pkg::RSC_HOLD;
        end
      end
      rsc_pkg::RSC_HOLD: begin
        sD.pend = allPend;
        if (~sPor & ~sBod & ~sPinLow & ~sDbg) begin
          sD.cnt        = initLen;
          sD.state      = rsc_pkg::RSC_INIT;
          sD.fuseReload = 1'b1;
        end
      end
      rsc_pkg::RSC_INIT: begin
        sD.pend = allPend;
        if (|nowReq) begin
          sD.state = rsc_pkg::RSC_HOLD;
        end else if (sQ.cnt <= rsc_pkg::CNT_W'(1)) begin
          sD.state = rsc_pkg::RSC_RUN;
          sD.pend  = '0;
          irqSet[rsc_pkg::IRQ_BOOT_DONE] = 1'b1;
          if (sQ.pend[rsc_pkg::FLAG_POR]) begin
            sD.flags = rsc_pkg::FLAGS_POR_ONLY;
          end else begin
            flagSet = sQ.pend;
          end
        end else begin
          sD.cnt = sQ.cnt - rsc_pkg::CNT_W'(1);
        end
      end
      default: sD.state = rsc_pkg::RSC_HOLD;
    endcase
    sD.initBusy = sD.state == rsc_pkg::RSC_INIT;

    if (wrOk && avs_address == rsc_pkg::ADDR_FLAGS && !sQ.pend[rsc_pkg::FLAG_POR]) begin
      sD.flags = sD.flags & ~avs_writedata[rsc_pkg::NFLAGS-1:0];
    end
    sD.flags = sD.flags | flagSet;

    irqSet[rsc_pkg::IRQ_REFUSED] = swRefuse;
    if (wrOk && avs_address == rsc_pkg::ADDR_IRQ_CLR) begin
      sD.irqStat = sQ.irqStat & ~avs_writedata[rsc_pkg::NIRQ-1:0];
    end
    sD.irqStat = sD.irqStat | irqSet;
    sD.irq     = |(sD.irqStat & sD.irqEn);

    if (sQ.fuseReload) begin
      sD.bodLevel = bodUsed ? bodLevelFuse : rsc_pkg::BOD_LEVEL_MIN;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sQ          <= '0;
      sQ.state    <= rsc_pkg::RSC_HOLD;
      sQ.pend     <= rsc_pkg::FLAGS_POR_ONLY;
      sQ.wait_    <= 1'b1;
      sQ.bodLevel <= rsc_pkg::BOD_LEVEL_MIN;
    end else begin
      sQ <= sD;
    end
  end

  assign fuseReload      = sQ.fuseReload;
  assign initBusy        = sQ.initBusy;
  assign bodLevel        = sQ.bodLevel;
  assign avs_readdata    = {24'h000000, sQ.rdata};
  assign avs_waitrequest = sQ.wait_;
  assign irq             = sQ.irq;

  sequence s_init_ends;
    sQ.state == rsc_pkg::RSC_INIT && sQ.cnt <= rsc_pkg::CNT_W'(1) && nowReq == '0;
  endsequence
  sequence s_sw_accept;
    wrOk && avs_address == rsc_pkg::ADDR_SOFT_RESET && sQ.unlock != 3'h0 &&
    avs_writedata[rsc_pkg::SOFT_TRIGGER_BIT];
  endsequence

  a_por_flag_only: assert property (@(posedge sys_clk) disable iff (!resetn)
    s_init_ends and sQ.pend[rsc_pkg::FLAG_POR] |=> sQ.flags == 6'h01)
    else $error("power-on did not leave only its flag");
  a_cause_recorded: assert property (@(posedge sys_clk) disable iff (!resetn)
    s_init_ends and sQ.pend[rsc_pkg::FLAG_WDT] |=> sQ.flags[rsc_pkg::FLAG_WDT])
    else $error("watchdog cause not recorded");
  a_por_holds: assert property (@(posedge sys_clk) disable iff (!resetn)
    porLowDet |=> !sysRstN)
    else $error("power-on request did not hold reset");
  a_bod_min_level: assert property (@(posedge sys_clk) disable iff (!resetn)
    sQ.fuseReload && !bodUsed |=> bodLevel == rsc_pkg::BOD_LEVEL_MIN)
    else $error("unused brown-out level not forced");
  a_pin_holds: assert property (@(posedge sys_clk) disable iff (!resetn)
    resetPinConfig && !resetPinN |=> !sysRstN)
    else $error("reset pin low did not hold reset");
  a_wdt_resets: assert property (@(posedge sys_clk) disable iff (!resetn)
    wdtExpire && sQ.state == rsc_pkg::RSC_RUN |=> sQ.state == rsc_pkg::RSC_HOLD ##[1:3] !sysRstN)
    else $error("watchdog time-out did not reset");
  a_sw_resets: assert property (@(posedge sys_clk) disable iff (!resetn)
    s_sw_accept |=> sQ.swReq ##1 sQ.state == rsc_pkg::RSC_HOLD)
    else $error("soft trigger did not start reset");
  a_locked_write: assert property (@(posedge sys_clk) disable iff (!resetn)
    wrOk && avs_address == rsc_pkg::ADDR_SOFT_RESET && sQ.unlock == 3'h0 |=> !sQ.swReq)
    else $error("unprotected soft reset write took effect");
  a_fuse_reload: assert property (@(posedge sys_clk) disable iff (!resetn)
    sQ.state == rsc_pkg::RSC_HOLD ##1 sQ.state == rsc_pkg::RSC_INIT |-> fuseReload)
    else $error("fuses not reloaded on release");
  a_debug_kept: assert property (@(posedge sys_clk) disable iff (!resetn)
    $fell(debugRstN) |-> porLowDet || bodLowDet || $past(porLowDet) || $past(bodLowDet) ||
    $past(pendPower) || $past(pendPower, 2))
    else $error("debug logic reset by a user source");
  a_trigger_reads0: assert property (@(posedge sys_clk) disable iff (!resetn)
    avs_read && !avs_waitrequest && avs_address == rsc_pkg::ADDR_SOFT_RESET |->
    avs_readdata == 32'h0)
    else $error("soft trigger read not zero");
  a_sync_release: assert property (@(posedge sys_clk) disable iff (!resetn)
    $rose(sysRstN) |-> $past(sQ.state, 2) == rsc_pkg::RSC_RUN)
    else $error("reset released without clocked permission");
  a_flags_w1c: assert property (@(posedge sys_clk) disable iff (!resetn)
    wrOk && avs_address == rsc_pkg::ADDR_FLAGS && !sQ.pend[rsc_pkg::FLAG_POR] &&
    sQ.state != rsc_pkg::RSC_INIT |=> (32'(sQ.flags) & $past(avs_writedata)) == 32'h0)
    else $error("written flag not cleared");
  a_refused_flag: assert property (@(posedge sys_clk) disable iff (!resetn)
    wrOk && avs_address == rsc_pkg::ADDR_SOFT_RESET && sQ.unlock == 3'h0 |=>
    sQ.irqStat[rsc_pkg::IRQ_REFUSED])
    else $error("refused protected write not flagged");
  a_flags_frozen: assert property (@(posedge sys_clk) disable iff (!resetn)
    sQ.pend[rsc_pkg::FLAG_POR] && sQ.state == rsc_pkg::RSC_HOLD |=> $stable(sQ.flags))
    else $error("flag changed before power-on boot ended");
  a_init_base: assert property (@(posedge sys_clk) disable iff (!resetn)
    sQ.state == rsc_pkg::RSC_HOLD ##1 sQ.state == rsc_pkg::RSC_INIT |->
    sQ.cnt >= rsc_pkg::CNT_W'(rsc_pkg::INIT_BASE_CYCLES))
    else $error("initialization shorter than its base");
  a_scan_longer: assert property (@(posedge sys_clk) disable iff (!resetn)
    sQ.state == rsc_pkg::RSC_HOLD ##1
    (sQ.state == rsc_pkg::RSC_INIT && startupScanSelect != rsc_pkg::SCAN_NONE) |->
    sQ.cnt >= rsc_pkg::CNT_W'(rsc_pkg::INIT_BASE_CYCLES + ScanCycles))
    else $error("startup scan did not lengthen initialization");
  a_reload_pulse: assert property (@(posedge sys_clk) disable iff (!resetn)
    fuseReload |=> !fuseReload)
    else $error("fuse reload longer than one cycle");
  a_bod_fuse_level: assert property (@(posedge sys_clk) disable iff (!resetn)
    sQ.fuseReload && bodUsed |=> bodLevel == $past(bodLevelFuse))
    else $error("brown-out level not taken from fuse");
  a_hold_on_req: assert property (@(posedge sys_clk) disable iff (!resetn)
    sQ.state == rsc_pkg::RSC_HOLD && (sPor || sBod || sPinLow || sDbg) |=>
    sQ.state == rsc_pkg::RSC_HOLD)
    else $error("released while a request was active");
endmodule // rsc_reset_manager
`default_nettype wire

// ==== testbench/rsc_source_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module rsc_source_model (
  // Clock and command from the bench
  input  wire logic       sys_clk,
  input  wire logic       go,
  input  wire logic [2:0] src,
  input  wire logic [3:0] holdCyc,
  // Requester lines
  output logic            porLowDet,
  output logic            bodLowDet,
  output logic            resetPinN,
  output logic            wdtExpire,
  output logic            debugRstReq
);
  logic [3:0] cnt_q = 4'h0;
  logic [2:0] cur_q = 3'h0;
  logic       on;
  // Source code equals its flag position
  always @(posedge sys_clk) begin
    if (go) begin
      cur_q <= src;
      cnt_q <= (src == 3'h3) ? 4'h1 : holdCyc;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end
  end
  always_comb begin
    on = cnt_q != 4'h0;
    porLowDet = on && cur_q == 3'h0;
    bodLowDet = on && cur_q == 3'h1;
    resetPinN = !(on && cur_q == 3'h2);
    wdtExpire = on && cur_q == 3'h3;
    debugRstReq = on && cur_q == 3'h5;
  end
endmodule // rsc_source_model
`default_nettype wire

// ==== testbench/testbench.sv ====
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic        sys_clk = 1'h0, resetn = 1'h0, resetPinConfig = 1'h1, bodUsed = 1'h1;
  logic [2:0]  startupDelaySetting = 3'h0, bodLevelFuse = 3'h0, bodLevel, src = 3'h0;
  logic [1:0]  startupScanSelect = 2'h0;
  logic        sysRstN, debugRstN, fuseReload, initBusy, irq, avs_waitrequest;
  logic        porLowDet, bodLowDet, resetPinN, wdtExpire, debugRstReq, go = 1'h0;
  logic [4:0]  avs_address = 5'h00;
  logic        avs_read = 1'h0, avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic [3:0]  avs_byteenable = 4'hF, holdCyc = 4'h1, be = 4'hF;
  logic [7:0]  expQ[$];
  int          errors = 0, tests_run = 0, seed = 86411, initCnt, reloads, base, sc, dly;
  bit          held = 1'h0, dbgLow;
  int          srcs[5] = '{3, 2, 5, 1, 0};

  rsc_reset_manager #(.StartupStepCycles(4), .ScanCycles(8)) dut_u (
    .sys_clk(sys_clk), .resetn(resetn), .porLowDet(porLowDet), .bodLowDet(bodLowDet),
    .resetPinN(resetPinN), .wdtExpire(wdtExpire), .debugRstReq(debugRstReq),
    .resetPinConfig(resetPinConfig), .startupDelaySetting(startupDelaySetting),
    .startupScanSelect(startupScanSelect), .bodUsed(bodUsed), .bodLevelFuse(bodLevelFuse),
    .sysRstN(sysRstN), .debugRstN(debugRstN), .fuseReload(fuseReload), .initBusy(initBusy),
    .bodLevel(bodLevel), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq));

  rsc_source_model model_u (
    .sys_clk(sys_clk), .go(go), .src(src), .holdCyc(holdCyc), .porLowDet(porLowDet),
    .bodLowDet(bodLowDet), .resetPinN(resetPinN), .wdtExpire(wdtExpire),
    .debugRstReq(debugRstReq));

  always #25 sys_clk = ~sys_clk;

  task automatic conclude;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Reads note their expected byte; hold keeps the strobe for a back-to-back access
  task automatic bus(input bit wr, input logic [4:0] a, input logic [7:0] d, input bit hold = 0);
    int n;
    n = 0;
    if (!held) @(posedge sys_clk);
    avs_address <= a;
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= wr ? {24'h0, d} : 32'h0;
    avs_byteenable <= be;
    if (!wr) expQ.push_back(d);
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'h0 && n < 50);
    if (n >= 50) errors++;
    if (!hold) begin
      avs_read <= 1'h0;
      avs_write <= 1'h0;
    end
    held = hold;
  endtask

  // Results appear in the cycle with waitrequest low
  always @(posedge sys_clk) begin
    if (avs_read && avs_waitrequest === 1'h0) chk("readdata", avs_readdata, {24'h0, expQ.pop_front()});
    initCnt += initBusy;
    reloads += fuseReload;
    if (debugRstN === 1'h0) dbgLow = 1'h1;
  end

  task automatic waitBoot;
    int n;
    n = 0;
    while (sysRstN !== 1'h0 && n < 20) begin
      @(posedge sys_clk);
      n++;
    end
    while (sysRstN !== 1'h1 && n < 2000) begin
      @(posedge sys_clk);
      n++;
    end
    chk("sysRstN released", sysRstN, 1'h1);
  endtask

  task automatic clearCounts;
    @(negedge sys_clk);
    initCnt = 0;
    reloads = 0;
    dbgLow = 1'h0;
  endtask

  task automatic pulse(input int s);
    @(posedge sys_clk);
    src <= 3'(s);
    holdCyc <= {1'h0, 3'($random(seed))} + 4'h1;
    go <= 1'h1;
    @(posedge sys_clk);
    go <= 1'h0;
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    conclude;
  end

  initial begin
    bodLevelFuse <= 3'($random(seed));
    repeat (10) @(posedge sys_clk);
    resetn <= 1'h1;
    waitBoot;
    bus(0, rsc_pkg::ADDR_FLAGS, 8'h01);
    bus(0, rsc_pkg::ADDR_SOFT_RESET, 8'h00);
    bus(0, 5'h1C, 8'h00);
    bus(0, rsc_pkg::ADDR_IRQ_STAT, 8'h01);
    be = 4'h0;
    bus(1, rsc_pkg::ADDR_FLAGS, 8'h01);
    be = 4'hF;
    bus(0, rsc_pkg::ADDR_FLAGS, 8'h01);
    bus(1, rsc_pkg::ADDR_FLAGS, 8'h3F);
    bus(0, rsc_pkg::ADDR_FLAGS, 8'h00);
    chk("irq masked", irq, 1'h0);
    bus(1, rsc_pkg::ADDR_IRQ_EN, 8'h03);
    bus(0, rsc_pkg::ADDR_IRQ_EN, 8'h03);
    chk("irq enabled", irq, 1'h1);
    bus(1, rsc_pkg::ADDR_IRQ_CLR, 8'h03);
    bus(0, rsc_pkg::ADDR_IRQ_STAT, 8'h00);
    chk("irq cleared", irq, 1'h0);
    // Protected write without the key is refused
    bus(1, rsc_pkg::ADDR_SOFT_RESET, 8'h01);
    bus(0, rsc_pkg::ADDR_IRQ_STAT, 8'h02);
    chk("irq refused", irq, 1'h1);
    chk("no soft reset", sysRstN, 1'h1);
    bus(1, rsc_pkg::ADDR_IRQ_CLR, 8'h03);
    clearCounts;
    bus(1, rsc_pkg::ADDR_PROTECT, rsc_pkg::IO_UNLOCK_KEY, 1);
    bus(1, rsc_pkg::ADDR_SOFT_RESET, 8'h01);
    waitBoot;
    chk("soft keeps debug", dbgLow, 1'h0);
    chk("soft reload", reloads, 1);
    bus(0, rsc_pkg::ADDR_FLAGS, 8'h10);
    // Disabled pin is ignored
    resetPinConfig <= 1'h0;
    pulse(2);
    repeat (10) @(posedge sys_clk);
    chk("pin ignored", sysRstN, 1'h1);
    resetPinConfig <= 1'h1;
    foreach (srcs[i]) begin
      bus(1, rsc_pkg::ADDR_FLAGS, 8'h3F);
      if (srcs[i] == 0) bodUsed <= 1'h0;
      clearCounts;
      pulse(srcs[i]);
      waitBoot;
      if (i == 0) base = initCnt;
      bus(0, rsc_pkg::ADDR_FLAGS, 8'(8'h01 << srcs[i]));
      chk("debug reset", dbgLow, srcs[i] < 2);
      chk("fuse reload", reloads, 1);
      chk("bod level", bodLevel, bodUsed ? bodLevelFuse : rsc_pkg::BOD_LEVEL_MIN);
    end
    // Delay counts for power resets only; scan for all
    dly = int'(3'($random(seed)) | 3'h1);
    startupDelaySetting <= 3'(dly);
    startupScanSelect <= 2'($random(seed)) | 2'h1;
    sc = 8;
    clearCounts;
    pulse(3);
    waitBoot;
    chk("wdog init", initCnt, base + sc);
    clearCounts;
    pulse(1);
    waitBoot;
    chk("brown init", initCnt, base + dly * 4 + sc);
    conclude;
  end
endmodule // testbench
`default_nettype wire
